// ==== bench/far_side.sv ====
`default_nettype none
module far_side (
   input wire logic clk_sys,
   input wire logic go,
   input wire logic [7:0] pulses,
   input wire logic se_force,
   input wire logic se_en,
   input wire logic compare_match,
   output logic ext_clock_pin,
   output logic special_event
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pin rests low between bursts
   initial ext_clock_pin = 1'h0;
   always begin
      @(posedge go);
      repeat (pulses) begin
         repeat (4) @(posedge clk_sys);
         ext_clock_pin <= 1'h1;
         repeat (4) @(posedge clk_sys);
         ext_clock_pin <= 1'h0;
      end
   end
   // Fires on se_force, or on a compare match while se_en is set
   assign special_event = se_force | (se_en & compare_match);
endmodule
`default_nettype wire

// ==== bench/tb_gated_timer.sv ====
`default_nettype none
module tb_gated_timer
   import tmr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'h0, rst = 1'h1, wr_stb = 1'h0, rd_stb = 1'h0, go = 1'h0, se_force = 1'h0, se_en = 1'h0;
   logic gate_pin = 1'h0, gate_pin_alt = 1'h0, cmp_out = 1'h0, iosc = 1'h0, sleep_mode = 1'h0, clk_en = 1'h1;
   logic capture_event = 1'h0, rd_d = 1'h0, ext_clock_pin, special_event, compare_match;
   logic lp_osc_active, irq_request, wake_request, vector_branch;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00, pulses = 8'h00, rdata;
   logic [15:0] ccv = 16'hfff8, lfsr = 16'hf887, count_value, captured_value;
   logic [15:0] exp_q[$];
   logic [7:0] rv[8] = '{CTRL_RST, 8'h00, 8'h00, CMP_CFG_RST, INT_CTRL_RST, 8'h00, 8'h00, 8'h00};
   int failures = 0, checks_done = 0, cycles = 0;
   always #4 clk_sys = ~clk_sys;
   gated_timer uut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata), .ext_clock_pin(ext_clock_pin), .lp_osc_clock(1'h0), .gate_pin(gate_pin),
      .gate_pin_alt(gate_pin_alt), .comparator_output(cmp_out), .internal_oscillator_no_clock_out(iosc),
      .sleep_mode(sleep_mode), .capture_event(capture_event), .special_event(special_event),
      .capture_compare_value(ccv), .count_value(count_value), .captured_value(captured_value),
      .compare_match(compare_match), .lp_osc_active(lp_osc_active), .irq_request(irq_request),
      .wake_request(wake_request), .vector_branch(vector_branch));
   far_side u_far (.clk_sys(clk_sys), .go(go), .pulses(pulses), .se_force(se_force), .se_en(se_en),
      .compare_match(compare_match), .ext_clock_pin(ext_clock_pin), .special_event(special_event));
   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task final_report;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'h1;
      @(posedge clk_sys);
      wr_stb <= 1'h0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      addr <= a;
      rd_stb <= 1'h1;
      exp_q.push_back({8'h00, e});
      @(posedge clk_sys);
      rd_stb <= 1'h0;
   endtask
   // Byte writes also restart the prescaler
   task automatic run(input logic [7:0] c, input int gap, input logic [7:0] e);
      wr(ADDR_CNT_LO, 8'h00);
      wr(ADDR_CNT_HI, 8'h00);
      wr(ADDR_CTRL, c);
      repeat (gap - 2) @(posedge clk_sys);
      wr(ADDR_CTRL, CTRL_RST);
      rd(ADDR_CNT_LO, e);
   endtask
   task automatic gcase(input logic [7:0] cfg, input logic [7:0] alt, input logic [7:0] c, input logic [2:0] p,
                        input logic [7:0] e);
      {gate_pin, gate_pin_alt, cmp_out} <= p;
      wr(ADDR_CMP_CFG, cfg);
      wr(ADDR_ALT, alt);
      run(c, 32, e);
   endtask
   task automatic ext(input logic [7:0] lo, input logic [7:0] c, input logic s, input logic [7:0] e);
      wr(ADDR_CTRL, CTRL_RST);
      wr(ADDR_CNT_LO, lo);
      wr(ADDR_CTRL, c);
      sleep_mode <= s;
      pulses <= 8'h03;
      go <= 1'h1;
      repeat (40) @(posedge clk_sys);
      go <= 1'h0;
      rd(ADDR_CNT_LO, e);
   endtask
   always @(posedge clk_sys) begin
      if (rd_d) chk({8'h00, rdata}, exp_q.pop_front());
      rd_d <= rd_stb;
      cycles++;
      if (cycles == 20000) begin
         failures++;
         final_report();
      end
   end
   initial begin
      repeat (10) @(posedge clk_sys);
      rst <= 1'h0;
      for (int i = 0; i < 8; i++) rd(3'(i), rv[i]);
      for (int i = 0; i < 4; i++) begin
         lfsr = nxt(lfsr);
         wr(ADDR_CMP_CFG, lfsr[7:0]);
         rd(ADDR_CMP_CFG, lfsr[7:0] & CMP_CFG_MASK);
         wr(ADDR_CTRL, lfsr[15:8] & 8'hfe);
         rd(ADDR_CTRL, lfsr[15:8] & 8'hfe);
      end
      wr(ADDR_CMP_CFG, 8'h10);
      for (int d = 0; d < 4; d++) run(8'(d << 4) | 8'h01, 64, 8'(64 >> d));
      wr(ADDR_CMP_CFG, 8'h00);
      run(8'h01, 64, 8'h10);
      gcase(8'h12, 8'h00, 8'hc1, 3'h4, 8'h20);
      gcase(8'h12, 8'h00, 8'h41, 3'h4, 8'h00);
      gcase(8'h12, 8'h10, 8'hc1, 3'h2, 8'h20);
      gcase(8'h10, 8'h00, 8'h41, 3'h6, 8'h20);
      gcase(8'h12, 8'h00, 8'hc0, 3'h4, 8'h00);
      wr(ADDR_CNT_HI, 8'hff);
      wr(ADDR_CNT_LO, 8'hfe);
      wr(ADDR_CTRL, 8'h01);
      repeat (2) @(posedge clk_sys);
      wr(ADDR_CTRL, 8'h00);
      rd(ADDR_CNT_LO, 8'h02);
      rd(ADDR_CNT_HI, 8'h00);
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_INT_CTRL, {i[1:0], 6'h00});
         wr(ADDR_PIE, {7'h00, i[2]});
         #1 chk(irq_request, i == 7);
      end
      rd(ADDR_PIR, 8'h01);
      wr(ADDR_PIR, 8'h00);
      rd(ADDR_PIR, 8'h00);
      se_en <= 1'h1;
      wr(ADDR_CNT_HI, 8'hff);
      wr(ADDR_CNT_LO, 8'hf0);
      wr(ADDR_CTRL, 8'h01);
      for (int i = 0; i < 100; i++) begin
         @(posedge clk_sys);
         lfsr = nxt(lfsr);
         capture_event <= lfsr[0];
      end
      capture_event <= 1'h0;
      wr(ADDR_CTRL, 8'h00);
      se_en <= 1'h0;
      rd(ADDR_PIR, 8'h00);
      @(posedge clk_sys);
      addr <= ADDR_CNT_LO;
      wdata <= 8'h5a;
      wr_stb <= 1'h1;
      se_force <= 1'h1;
      @(posedge clk_sys);
      wr_stb <= 1'h0;
      se_force <= 1'h0;
      rd(ADDR_CNT_LO, 8'h5a);
      wr(ADDR_CTRL, 8'h08);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_sys);
         iosc <= i[0];
         #1 chk(lp_osc_active, i[0]);
      end
      wr(ADDR_INT_CTRL, 8'h40);
      wr(ADDR_CNT_HI, 8'hff);
      ext(8'hfe, 8'h07, 1'h1, 8'h00);
      #1 chk(wake_request, 1'h1);
      chk(vector_branch, 1'h0);
      wr(ADDR_INT_CTRL, 8'hc0);
      #1 chk(vector_branch, 1'h1);
      ext(8'h00, 8'h03, 1'h1, 8'h00);
      ext(8'h00, 8'h03, 1'h0, 8'h02);
      // Oscillator path idles low, so pin pulses must not count
      ext(8'h00, 8'h0b, 1'h0, 8'h00);
      wr(ADDR_CTRL, CTRL_RST);
      wr(ADDR_CNT_LO, 8'h00);
      wr(ADDR_CTRL, 8'h01);
      clk_en <= 1'h0;
      repeat (8) @(posedge clk_sys);
      clk_en <= 1'h1;
      wr(ADDR_CTRL, CTRL_RST);
      rd(ADDR_CNT_LO, 8'h02);
      final_report();
   end
endmodule
`default_nettype wire

// ==== bench/tmr_monitor.sv ====
`default_nettype none
module tmr_monitor
   import tmr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] rdata,
   input wire logic sleep_mode,
   input wire logic capture_event,
   input wire logic special_event,
   input wire logic internal_oscillator_no_clock_out,
   input wire logic [15:0] capture_compare_value,
   input wire logic [15:0] count_value,
   input wire logic [15:0] captured_value,
   input wire logic compare_match,
   input wire logic lp_osc_active,
   input wire logic wake_request,
   input wire logic vector_branch
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ****
   // Port relations
   // ****
   property p_rd_idle; !$past(rd_stb) |-> rdata == BYTE_ZERO; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
   property p_step;
      !$past(rst) && !$past(wr_stb) && !$past(special_event) && count_value != $past(count_value)
      |-> count_value == $past(count_value) + 16'h0001;
   endproperty
   a_step: assert property (p_step) else $error("counter jumped");
   property p_sev; special_event && clk_en && !wr_stb |=> count_value == CNT_RST; endproperty
   a_sev: assert property (p_sev) else $error("trigger did not clear");
   property p_wr_win; special_event && clk_en && wr_stb && addr == ADDR_CNT_LO |=> count_value[7:0] == $past(wdata);
   endproperty
   a_wr_win: assert property (p_wr_win) else $error("write lost to trigger");
   property p_cap; capture_event && clk_en |=> captured_value == $past(count_value); endproperty
   a_cap: assert property (p_cap) else $error("capture wrong");
   property p_cmp;
      !$past(rst) && $past(clk_en) |-> compare_match == ($past(capture_compare_value) == $past(count_value));
   endproperty
   a_cmp: assert property (p_cmp) else $error("compare wrong");
   property p_lp; lp_osc_active |-> internal_oscillator_no_clock_out; endproperty
   a_lp: assert property (p_lp) else $error("oscillator on wrongly");
   property p_wake; wake_request |-> sleep_mode; endproperty
   a_wake: assert property (p_wake) else $error("wake while awake");
   property p_vec; vector_branch |-> wake_request; endproperty
   a_vec: assert property (p_vec) else $error("vector without wake");
   c_wrap: cover property (count_value == CNT_MAX ##1 count_value == CNT_RST);
   c_sev: cover property (special_event && !wr_stb);
   c_vec: cover property (vector_branch);
endmodule
bind gated_timer tmr_monitor u_mon (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .addr(addr),
   .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .sleep_mode(sleep_mode),
   .capture_event(capture_event), .special_event(special_event),
   .internal_oscillator_no_clock_out(internal_oscillator_no_clock_out),
   .capture_compare_value(capture_compare_value), .count_value(count_value), .captured_value(captured_value),
   .compare_match(compare_match), .lp_osc_active(lp_osc_active), .wake_request(wake_request),
   .vector_branch(vector_branch));
`default_nettype wire

// ==== logic/gated_timer.sv ====
// The plain strobed port and the address map are this design's own decisions.
`default_nettype none
module gated_timer
   import tmr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rdata,
   input wire logic ext_clock_pin,
   input wire logic lp_osc_clock,
   input wire logic gate_pin,
   input wire logic gate_pin_alt,
   input wire logic comparator_output,
   input wire logic internal_oscillator_no_clock_out,
   input wire logic sleep_mode,
   input wire logic capture_event,
   input wire logic special_event,
   input wire logic [15:0] capture_compare_value,
   output logic [15:0] count_value,
   output logic [15:0] captured_value,
   output logic compare_match,
   output logic lp_osc_active,
   output logic irq_request,
   output logic wake_request,
   output logic vector_branch
);

   // ****************************************
   // State
   // ****************************************
   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   logic [7:0] cmp_cfg_q;
   logic [7:0] cmp_cfg_d;
   logic [7:0] int_ctrl_q;
   logic [7:0] int_ctrl_d;
   logic pie_q;
   logic pie_d;
   logic flag_q;
   logic flag_d;
   logic galt_q;
   logic galt_d;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [2:0] pre_q;
   logic [2:0] pre_d;
   logic [1:0] idiv_q;
   logic [1:0] idiv_d;
   logic arm_q;
   logic arm_d;
   logic ext_prev_q;
   logic [SYN_W-1:0] syn1_q;
   logic [SYN_W-1:0] syn2_q;
   logic [7:0] rdata_q;
   logic [15:0] cap_q;
   logic match_q;

   // ****************************************
   // Register decode
   // ****************************************
   wire wr_ctrl = wr_stb && (addr == ADDR_CTRL);
   wire wr_lo = wr_stb && (addr == ADDR_CNT_LO);
   wire wr_hi = wr_stb && (addr == ADDR_CNT_HI);
   wire wr_cmp = wr_stb && (addr == ADDR_CMP_CFG);
   wire wr_int = wr_stb && (addr == ADDR_INT_CTRL);
   wire wr_pie = wr_stb && (addr == ADDR_PIE);
   wire wr_pir = wr_stb && (addr == ADDR_PIR);
   wire wr_alt = wr_stb && (addr == ADDR_ALT);
   wire wr_cnt = wr_lo || wr_hi;

   // Byte reads come from the live counter, so each byte is self-consistent
   wire [7:0] rd_mux =
      (addr == ADDR_CTRL) ? ctrl_q :
      (addr == ADDR_CNT_LO) ? cnt_q[7:0] :
      (addr == ADDR_CNT_HI) ? cnt_q[15:8] :
      (addr == ADDR_CMP_CFG) ? cmp_cfg_q :
      (addr == ADDR_INT_CTRL) ? int_ctrl_q :
      (addr == ADDR_PIE) ? {7'h00, pie_q} :
      (addr == ADDR_PIR) ? {7'h00, flag_q} :
      (galt_q ? ALT_MASK : BYTE_ZERO);

   // ****************************************
   // Control fields
   // ****************************************
   wire run_en = ctrl_q[BIT_RUN];
   wire ext_sel = ctrl_q[BIT_SRC];
   wire sync_dis = ctrl_q[BIT_SYNC_DIS];
   wire gate_en = ctrl_q[BIT_GATE_EN];
   wire gate_pol = ctrl_q[BIT_GATE_POL];
   wire [1:0] div_sel = ctrl_q[BIT_DIV_HI:BIT_DIV_LO];
   wire fast_sel = cmp_cfg_q[BIT_FAST];
   wire gss = cmp_cfg_q[BIT_GSS];

   // ****************************************
   // Clock source selection
   // ****************************************
   // Oscillator runs only behind the internal oscillator without clock out
   assign lp_osc_active = ctrl_q[BIT_LPOSC] && internal_oscillator_no_clock_out;
   wire ext_level = lp_osc_active ? syn2_q[SYN_LPOSC] : syn2_q[SYN_EXT];
   wire ext_rise = ext_level && !ext_prev_q;
   wire ext_fall = !ext_level && ext_prev_q;
   wire instr_tick = (idiv_q == INSTR_DIV_MAX);
   wire int_tick = fast_sel ? 1'b1 : instr_tick;
   // Pin source counts rising edges only once armed by a falling edge
   wire src_tick = ext_sel ? (ext_rise && arm_q) : int_tick;

   // ****************************************
   // Gate and run qualification
   // ****************************************
   wire gate_raw = gss ? (galt_q ? syn2_q[SYN_GALT] : syn2_q[SYN_GATE])
                       : syn2_q[SYN_CMP];
   wire gate_act = gate_pol ? gate_raw : !gate_raw;
   wire count_on = run_en && (!gate_en || gate_act);
   // Sync-disable is looked at only with the external source
   wire async_ext = ext_sel && sync_dis;
   wire sleep_ok = !sleep_mode || async_ext;
   wire step = src_tick && count_on && sleep_ok;

   // ****************************************
   // Prescaler
   // ****************************************
   wire [2:0] pre_max =
      (div_sel == DIV_CODE_1) ? PRE_MAX_1 :
      (div_sel == DIV_CODE_2) ? PRE_MAX_2 :
      (div_sel == DIV_CODE_4) ? PRE_MAX_4 : PRE_MAX_8;
   wire pre_wrap = (pre_q == pre_max);
   wire inc = step && pre_wrap;
   wire ovf_set = inc && (cnt_q == CNT_MAX);

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      ctrl_d = wr_ctrl ? wdata : ctrl_q;
      cmp_cfg_d = wr_cmp ? (wdata & CMP_CFG_MASK) : cmp_cfg_q;
      int_ctrl_d = wr_int ? wdata : int_ctrl_q;
      pie_d = wr_pie ? wdata[BIT_OVF] : pie_q;
      galt_d = wr_alt ? wdata[BIT_GALT] : galt_q;
      idiv_d = idiv_q + 2'h1;
   end

   // Hardware set wins over a same-cycle software clear
   always_comb begin
      flag_d = flag_q;
      if (wr_pir) begin
         flag_d = wdata[BIT_OVF];
      end
      if (ovf_set) begin
         flag_d = 1'b1;
      end
   end

   // Byte writes take priority over both clear and increment
   always_comb begin
      cnt_d = cnt_q;
      if (wr_lo) begin
         cnt_d = {cnt_q[15:8], wdata};
      end else if (wr_hi) begin
         cnt_d = {wdata, cnt_q[7:0]};
      end else if (special_event) begin
         cnt_d = CNT_RST;
      end else if (inc) begin
         cnt_d = cnt_q + 16'h0001;
      end
   end

   always_comb begin
      pre_d = pre_q;
      if (wr_cnt) begin
         pre_d = PRE_MAX_1;
      end else if (step) begin
         pre_d = pre_wrap ? PRE_MAX_1 : (pre_q + 3'h1);
      end
   end

   // Disarm after a counter byte write, or while stopped with the pin high
   always_comb begin
      arm_d = arm_q;
      if (wr_cnt || (!run_en && ext_level)) begin
         arm_d = 1'b0;
      end else if (ext_fall) begin
         arm_d = 1'b1;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   // Only power-on reset exists here, so control always starts cleared
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_q <= CTRL_RST;
      end else if (clk_en) begin
         ctrl_q <= ctrl_d;
      end
   end

   // Unused bits are masked at the write and read back as zero
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cmp_cfg_q <= CMP_CFG_RST;
      end else if (clk_en) begin
         cmp_cfg_q <= cmp_cfg_d;
      end
   end

   // All bits stored; only the two enables are used here
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         int_ctrl_q <= INT_CTRL_RST;
      end else if (clk_en) begin
         int_ctrl_q <= int_ctrl_d;
      end
   end

   // Only the overflow bits of the enable and flag bytes exist
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pie_q <= 1'b0;
      end else if (clk_en) begin
         pie_q <= pie_d;
      end
   end

   // Cleared only by software; overflow may set it again in the same cycle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         flag_q <= 1'b0;
      end else if (clk_en) begin
         flag_q <= flag_d;
      end
   end

   // Alternate gate pin choice lives in its own index
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         galt_q <= 1'b0;
      end else if (clk_en) begin
         galt_q <= galt_d;
      end
   end

   // Cleared at reset for determinism; software should still load it
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_q <= CNT_RST;
      end else if (clk_en) begin
         cnt_q <= cnt_d;
      end
   end

   // Hidden prescaler, never visible on the bus
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pre_q <= PRE_MAX_1;
      end else if (clk_en) begin
         pre_q <= pre_d;
      end
   end

   // Free-running divide by four, so its phase is not tied to run enable
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         idiv_q <= 2'h0;
      end else if (clk_en) begin
         idiv_q <= idiv_d;
      end
   end

   // Pin clock stays disarmed until a falling edge is seen
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         arm_q <= 1'b0;
      end else if (clk_en) begin
         arm_q <= arm_d;
      end
   end

   // Pins are foreign to clk_sys; only the second stage is read
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         syn1_q <= '0;
         syn2_q <= '0;
      end else if (clk_en) begin
         syn1_q <= {comparator_output, gate_pin_alt, gate_pin, lp_osc_clock, ext_clock_pin};
         syn2_q <= syn1_q;
      end
   end

   // Resets low like an idle pin, so no false edge follows reset
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ext_prev_q <= 1'b0;
      end else if (clk_en) begin
         ext_prev_q <= ext_level;
      end
   end

   // ****************************************
   // Read port and time base outputs
   // ****************************************
   // Zero outside its slot, so a stray strobe is easy to spot
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdata_q <= BYTE_ZERO;
      end else if (clk_en) begin
         rdata_q <= rd_stb ? rd_mux : BYTE_ZERO;
      end
   end

   // Capture samples the live counter on every clock edge while capture_event is high
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cap_q <= CNT_RST;
      end else if (clk_en) begin
         cap_q <= capture_event ? cnt_q : cap_q;
      end
   end

   // Match lags the counter by one cycle; a trigger clears on the next edge
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         match_q <= 1'b0;
      end else if (clk_en) begin
         match_q <= (capture_compare_value == cnt_q);
      end
   end

   assign rdata = rdata_q;
   assign count_value = cnt_q;
   assign captured_value = cap_q;
   assign compare_match = match_q;

   // ****************************************
   // Interrupt and wake requests
   // ****************************************
   // Requests are levels built from registers; the core decides what to do
   wire periph_req = flag_q && pie_q && int_ctrl_q[BIT_PERIPH_EN];
   assign irq_request = periph_req && int_ctrl_q[BIT_GLOBAL_EN];
   // Wake ignores the global enable; it only picks vector or next instruction
   assign wake_request = sleep_mode && periph_req && run_en;
   assign vector_branch = wake_request && int_ctrl_q[BIT_GLOBAL_EN];

endmodule
`default_nettype wire

// ==== shared/tmr_pkg.sv ====
`default_nettype none
package tmr_pkg;
   // ****************************************
   // Register indices on the plain port
   // ****************************************
   localparam logic [2:0] ADDR_CTRL = 3'h0;
   localparam logic [2:0] ADDR_CNT_LO = 3'h1;
   localparam logic [2:0] ADDR_CNT_HI = 3'h2;
   localparam logic [2:0] ADDR_CMP_CFG = 3'h3;
   localparam logic [2:0] ADDR_INT_CTRL = 3'h4;
   localparam logic [2:0] ADDR_PIE = 3'h5;
   localparam logic [2:0] ADDR_PIR = 3'h6;
   localparam logic [2:0] ADDR_ALT = 3'h7;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int BIT_RUN = 0;
   localparam int BIT_SRC = 1;
   localparam int BIT_SYNC_DIS = 2;
   localparam int BIT_LPOSC = 3;
   localparam int BIT_DIV_LO = 4;
   localparam int BIT_DIV_HI = 5;
   localparam int BIT_GATE_EN = 6;
   localparam int BIT_GATE_POL = 7;
   localparam int BIT_FAST = 4;
   localparam int BIT_GSS = 1;
   localparam int BIT_GLOBAL_EN = 7;
   localparam int BIT_PERIPH_EN = 6;
   localparam int BIT_OVF = 0;
   localparam int BIT_GALT = 4;

   // ****************************************
   // Reset values and masks
   // ****************************************
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] CMP_CFG_RST = 8'h02;
   localparam logic [7:0] CMP_CFG_MASK = 8'h1b;
   localparam logic [7:0] INT_CTRL_RST = 8'h00;
   localparam logic [7:0] ALT_MASK = 8'h10;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hffff;

   // ****************************************
   // Divider codes and terminal counts
   // ****************************************
   localparam logic [1:0] DIV_CODE_1 = 2'h0;
   localparam logic [1:0] DIV_CODE_2 = 2'h1;
   localparam logic [1:0] DIV_CODE_4 = 2'h2;
   localparam logic [2:0] PRE_MAX_1 = 3'h0;
   localparam logic [2:0] PRE_MAX_2 = 3'h1;
   localparam logic [2:0] PRE_MAX_4 = 3'h3;
   localparam logic [2:0] PRE_MAX_8 = 3'h7;
   localparam logic [1:0] INSTR_DIV_MAX = 2'h3;

   // Synchroniser lanes
   localparam int SYN_EXT = 0;
   localparam int SYN_LPOSC = 1;
   localparam int SYN_GATE = 2;
   localparam int SYN_GALT = 3;
   localparam int SYN_CMP = 4;
   localparam int SYN_W = 5;
endpackage
`default_nettype wire
